/* File: verilog/apms_pkg.sv */
// Purpose: Shared constants and types for the amplifier power and mute sequencer
// Assumes: 25 MHz system clock
// Notes: Analog thresholds arrive as comparator levels
package apms_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int FAST_MUTE_US = 400;
    localparam int FAST_MUTE_CYC = FAST_MUTE_US * (CLK_HZ / 1000000);
    localparam int SOFT_MUTE_US = 20000;
    localparam int SOFT_MUTE_CYC = SOFT_MUTE_US * (CLK_HZ / 1000000);
    localparam int FAULT_CHECK_US = 100;
    localparam int FAULT_CHECK_CYC = FAULT_CHECK_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 20;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        APMS_STB_LOW,
        APMS_STB_MUTE,
        APMS_STB_ON
    } apms_stb_e;

    // Comparator outputs from the analog front end
    typedef struct packed {
        logic vp_below_10v;
        logic vp_below_low_mute;
        logic vp_above_restart;
        logic svr_at_half;
        logic svr_below_0v7;
        logic por_event;
    } apms_sense_s;

    // Analog control strobes toward the amplifier
    typedef struct packed {
        logic ramp_enable;
        logic mute;
        logic fast_mute;
        logic svr_discharge;
        logic ac_ground_cap_discharge;
        logic fault_check;
        logic best_eff_enable;
        logic dc_follow_half_supply;
        logic threshold_7v2;
    } apms_ctrl_s;

endpackage

/* File: verilog/apms_stb_decode.sv */
// Purpose: Classifies the standby pin level and the operating mode
// Assumes: Level comparators are synchronous to sys_clk
// Notes: Legacy mode gives three levels, bus mode only low or high
`timescale 1ns/1ps
module apms_stb_decode
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic address_select_grounded,
    input wire logic stb_above_2v5,
    input wire logic stb_above_5v9,
    output apms_pkg::apms_stb_e stb_level,
    output logic legacy_mode
);
    wire apms_pkg::apms_stb_e next_stb_level;

    // Between 2.5 V and 5.9 V decodes as mute in legacy mode; bus mode reads it as on
    assign next_stb_level = !stb_above_2v5 ? apms_pkg::APMS_STB_LOW :
        (stb_above_5v9 || !address_select_grounded) ? apms_pkg::APMS_STB_ON :
        apms_pkg::APMS_STB_MUTE;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            stb_level <= apms_pkg::APMS_STB_LOW;
            legacy_mode <= 1'b0;
        end
        else
        begin
            stb_level <= next_stb_level;
            legacy_mode <= address_select_grounded;
        end
    end
endmodule

/* File: verilog/apms_timer.sv */
// Purpose: Reloadable down counter with a done flag
// Assumes: Load takes priority over counting
// Notes: Done holds until the next load
`timescale 1ns/1ps
module apms_timer #(
    parameter int W = 20
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_value,
    output logic done
);
    logic [W-1:0] count;
    wire at_zero = (count == '0);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            count <= '0;
            done <= 1'b0;
        end
        else if (load)
        begin
            count <= load_value;
            done <= 1'b0;
        end
        else if (!at_zero)
        begin
            count <= count - 1'b1;
            done <= (count == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule

/* File: verilog/apms_sequencer.sv */
// Purpose: Power-up, mute and shut-down sequencer of a quad audio amplifier
// Assumes: All inputs synchronous to sys_clk; comparators already filtered
// Notes: Counts shortenable by module parameters
`timescale 1ns/1ps
module apms_sequencer #(
    parameter int FAST_MUTE_CYC = apms_pkg::FAST_MUTE_CYC,
    parameter int SOFT_MUTE_CYC = apms_pkg::SOFT_MUTE_CYC,
    parameter int FAULT_CHECK_CYC = apms_pkg::FAULT_CHECK_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic address_select_grounded,
    input wire logic stb_above_2v5,
    input wire logic stb_above_5v9,
    input wire logic amplifier_on_bit,
    input wire logic mute_bits,
    input wire logic threshold_7v2_select,
    input wire logic best_eff_request,
    input apms_pkg::apms_sense_s sense,
    output apms_pkg::apms_ctrl_s ctrl,
    output logic power_on_reset_flag,
    output logic diagnostic_flag_pin_out,
    output logic diagnostic_flag_pin_oe_n,
    output logic speaker_check_done
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    typedef enum logic [2:0] {
        S_OFF,
        S_RAMP,
        S_HOLD,
        S_CHECK,
        S_ON,
        S_MUTING,
        S_DISCHARGE
    } apms_state_e;

    apms_state_e state;
    apms_state_e next_state;
    apms_pkg::apms_stb_e stb_level;
    logic legacy_mode;
    logic fast_path;
    logic low_supply_path;
    logic auto_restart;
    logic amp_on_d;
    logic timer_done;
    logic timer_load;
    logic [apms_pkg::CNT_W-1:0] timer_value;

    // ----------------------------------------
    // Pin level decode and delay timer
    // ----------------------------------------
    apms_stb_decode u_stb
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .address_select_grounded(address_select_grounded),
        .stb_above_2v5(stb_above_2v5),
        .stb_above_5v9(stb_above_5v9),
        .stb_level(stb_level),
        .legacy_mode(legacy_mode)
    );

    apms_timer #(.W(apms_pkg::CNT_W)) u_timer
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(timer_load),
        .load_value(timer_value),
        .done(timer_done)
    );

    // ----------------------------------------
    // Requests
    // ----------------------------------------
    wire bus_on = !legacy_mode && amplifier_on_bit;
    wire pin_on = stb_level != apms_pkg::APMS_STB_LOW;
    wire switch_on = legacy_mode ? pin_on : (bus_on && pin_on);
    wire unmute = legacy_mode ? (stb_level == apms_pkg::APMS_STB_ON)
                              : !mute_bits;
    wire pin_low = stb_level == apms_pkg::APMS_STB_LOW;
    wire use_7v2 = !legacy_mode && threshold_7v2_select;
    wire low_supply = sense.vp_below_low_mute;
    wire amp_on_rise = bus_on && !amp_on_d;
    // Restart needs recovered supply, empty reference cap and no reset flag;
    // legacy mode has no host to clear the flag so the pin level decides.
    wire restart_ok = sense.vp_above_restart && sense.svr_below_0v7 &&
        (legacy_mode || !power_on_reset_flag);
    wire soft_off = !legacy_mode && !amplifier_on_bit;

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        timer_load = 1'b0;
        timer_value = '0;
        unique case (state)
            S_OFF:
            begin
                // A reset flag blocks bus start until the host sets amplifier-on again
                if (auto_restart ? (restart_ok && switch_on) :
                    (switch_on && sense.svr_below_0v7 && !low_supply &&
                    (legacy_mode || amp_on_rise || !power_on_reset_flag)))
                    next_state = S_RAMP;
            end
            S_RAMP:
            begin
                if (pin_low || low_supply || soft_off)
                begin
                    next_state = S_MUTING;
                    timer_load = 1'b1;
                    timer_value = apms_pkg::CNT_W'(FAST_MUTE_CYC);
                end
                else if (sense.svr_at_half)
                    next_state = S_HOLD;
            end
            S_HOLD:
            begin
                if (pin_low || low_supply || soft_off)
                begin
                    next_state = S_MUTING;
                    timer_load = 1'b1;
                    timer_value = apms_pkg::CNT_W'(FAST_MUTE_CYC);
                end
                else if (unmute)
                begin
                    next_state = S_CHECK;
                    timer_load = 1'b1;
                    timer_value = apms_pkg::CNT_W'(FAULT_CHECK_CYC);
                end
            end
            S_CHECK:
            begin
                if (pin_low || low_supply || soft_off)
                begin
                    next_state = S_MUTING;
                    timer_load = 1'b1;
                    timer_value = apms_pkg::CNT_W'(FAST_MUTE_CYC);
                end
                else if (timer_done)
                    next_state = S_ON;
            end
            S_ON:
            begin
                if (pin_low || low_supply)
                begin
                    next_state = S_MUTING;
                    timer_load = 1'b1;
                    timer_value = apms_pkg::CNT_W'(FAST_MUTE_CYC);
                end
                else if (soft_off)
                begin
                    next_state = S_MUTING;
                    timer_load = 1'b1;
                    timer_value = apms_pkg::CNT_W'(SOFT_MUTE_CYC);
                end
                else if (!unmute)
                    next_state = S_HOLD;
            end
            S_MUTING:
            begin
                if (timer_done)
                    next_state = S_DISCHARGE;
            end
            S_DISCHARGE:
            begin
                if (sense.svr_below_0v7)
                    next_state = S_OFF;
            end
        endcase
        // Outputs follow next_state, so a reset event must steer it too
        if (sense.por_event)
        begin
            next_state = S_OFF;
            timer_load = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            state <= S_OFF;
        else if (sense.por_event)
            state <= S_OFF;
        else
            state <= next_state;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            amp_on_d <= 1'b0;
            fast_path <= 1'b0;
            low_supply_path <= 1'b0;
            auto_restart <= 1'b0;
        end
        else
        begin
            amp_on_d <= bus_on;
            if (timer_load)
            begin
                fast_path <= pin_low || low_supply || state != S_ON;
                low_supply_path <= low_supply;
            end
            // Low-supply shutdown arms the automatic restart
            if (sense.por_event || pin_low || soft_off)
                auto_restart <= 1'b0;
            else if (timer_load && low_supply)
                auto_restart <= 1'b1;
            else if (state == S_RAMP)
                auto_restart <= 1'b0;
        end
    end

    // Power-on flag: reset event sets, amplifier-on rising edge clears, set wins
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            power_on_reset_flag <= 1'b1;
        else if (sense.por_event)
            power_on_reset_flag <= 1'b1;
        else if (amp_on_rise)
            power_on_reset_flag <= 1'b0;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl <= '0;
            diagnostic_flag_pin_out <= 1'b0;
            diagnostic_flag_pin_oe_n <= 1'b1;
            speaker_check_done <= 1'b0;
        end
        else
        begin
            ctrl.ramp_enable <= next_state inside {S_RAMP, S_HOLD, S_CHECK, S_ON};
            ctrl.mute <= next_state != S_ON;
            ctrl.fast_mute <= next_state == S_MUTING && (timer_load ?
                (pin_low || low_supply || state != S_ON) : fast_path);
            ctrl.fault_check <= next_state == S_CHECK;
            ctrl.svr_discharge <= next_state == S_DISCHARGE;
            ctrl.ac_ground_cap_discharge <= next_state == S_DISCHARGE && low_supply_path;
            // Start-up and shut-down stay in plain bridge mode
            ctrl.best_eff_enable <= (legacy_mode || best_eff_request) &&
                !sense.vp_below_10v && next_state == S_ON;
            ctrl.dc_follow_half_supply <= sense.vp_below_10v;
            ctrl.threshold_7v2 <= use_7v2;
            // Open-drain: enable low pulls the pin low
            diagnostic_flag_pin_oe_n <= !(power_on_reset_flag && !legacy_mode);
            if (state == S_CHECK && timer_done)
                speaker_check_done <= 1'b1;
            else if (state == S_OFF)
                speaker_check_done <= 1'b0;
        end
    end
endmodule

/* File: verification/apms_seq_asserts.sv */
// Purpose: Temporal checks on the sequencer ports
// Assumes: One clock, sync active-low reset
// Notes: Windows allow for the pin register stage
`timescale 1ns/1ps
module apms_seq_asserts #(
    parameter int FAST_MUTE_CYC = 8
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic address_select_grounded,
    input wire logic stb_above_2v5,
    input wire logic amplifier_on_bit,
    input apms_pkg::apms_sense_s sense,
    input apms_pkg::apms_ctrl_s ctrl,
    input wire logic power_on_reset_flag,
    input wire logic diagnostic_flag_pin_out,
    input wire logic diagnostic_flag_pin_oe_n,
    input wire logic speaker_check_done
);
    // ----
    // Helpers
    // ----
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    int fm_cnt;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !ctrl.fast_mute)
            fm_cnt <= 0;
        else
            fm_cnt <= fm_cnt + 1;
    end
    sequence s_run;
        speaker_check_done && !ctrl.mute;
    endsequence
    sequence s_bus_on;
        amplifier_on_bit && !address_select_grounded && !sense.por_event;
    endsequence
    chk_be_low: assert property (sense.vp_below_10v [*3] |-> !ctrl.best_eff_enable)
        else $error("best efficiency on at low battery");
    chk_dc_filtered: assert property (!sense.vp_below_10v [*3] |-> !ctrl.dc_follow_half_supply)
        else $error("output follows supply at high battery");
    chk_diagnostic_flag_pin_low: assert property (!diagnostic_flag_pin_oe_n |-> !diagnostic_flag_pin_out &&
        (power_on_reset_flag || $past(power_on_reset_flag)))
        else $error("diagnostic pin low without reset flag");
    chk_flag_clear: assert property (!amplifier_on_bit ##1 s_bus_on [*3] |->
        !power_on_reset_flag)
        else $error("reset flag kept after amplifier on");
    chk_por_off: assert property (sense.por_event |=> power_on_reset_flag && !ctrl.ramp_enable)
        else $error("power-on reset left amplifier running");
    chk_ramp_start: assert property ($rose(ctrl.ramp_enable) |->
        ctrl.mute && $past(sense.svr_below_0v7))
        else $error("ramp unmuted or reference not discharged");
    chk_check_first: assert property ($fell(ctrl.mute) && !ctrl.svr_discharge &&
        !$past(ctrl.svr_discharge) && !$past(sense.por_event) |-> $past(ctrl.fault_check))
        else $error("mute released without fault check");
    chk_low_fast: assert property (sense.vp_below_low_mute ##0 s_run |-> ##[1:3] ctrl.fast_mute)
        else $error("low supply not fast muted");
    chk_pin_fast: assert property (!stb_above_2v5 ##0 s_run |-> ##[1:4] ctrl.fast_mute)
        else $error("standby low not fast muted");
    chk_disch_after: assert property ($rose(ctrl.svr_discharge) |-> $past(ctrl.mute))
        else $error("discharge before mute");
    chk_ac_ground_cap_wait: assert property ($rose(ctrl.ac_ground_cap_discharge) |->
        fm_cnt >= FAST_MUTE_CYC - 2)
        else $error("ground discharge before fast mute done");
    chk_legacy_thr: assert property (address_select_grounded [*3] |-> !ctrl.threshold_7v2)
        else $error("high threshold in legacy mode");
endmodule
bind apms_sequencer apms_seq_asserts #(.FAST_MUTE_CYC(FAST_MUTE_CYC)) u_chk (.sys_clk, .rst_n,
    .address_select_grounded, .stb_above_2v5, .amplifier_on_bit, .sense, .ctrl,
    .power_on_reset_flag, .diagnostic_flag_pin_out, .diagnostic_flag_pin_oe_n,
    .speaker_check_done);

/* File: verification/apms_svr_model.sv */
// Purpose: Supply reference capacitor beside the sequencer
// Assumes: Charge and discharge take LVL cycles
// Notes: Bleeds while the amplifier is off, so a reset leaves it empty
`timescale 1ns/1ps
module apms_svr_model #(
    parameter int LVL = 12
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input apms_pkg::apms_ctrl_s ctrl,
    output logic svr_at_half,
    output logic svr_below_0v7
);
    int lvl;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            lvl <= 0;
        else if ((ctrl.svr_discharge || !ctrl.ramp_enable) && lvl > 0)
            lvl <= lvl - 1;
        else if (ctrl.ramp_enable && !ctrl.svr_discharge && lvl < LVL)
            lvl <= lvl + 1;
    end
    assign svr_at_half = (lvl == LVL);
    assign svr_below_0v7 = (lvl == 0);
endmodule

/* File: verification/tb.sv */
// Purpose: Scenario bench for the sequencer
// Assumes: Shortened counts 8, 16 and 4 cycles
// Notes: Inputs change by NBA at posedge, outputs read at negedge
`timescale 1ns/1ps
module tb;
    localparam int FM = 8;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic address_select_grounded = 1'b0;
    logic stb_above_2v5 = 1'b1;
    logic stb_above_5v9 = 1'b0;
    logic amplifier_on_bit = 1'b0;
    logic mute_bits = 1'b1;
    logic threshold_7v2_select = 1'b0;
    logic best_eff_request = 1'b0;
    logic vp_below_10v = 1'b0;
    logic vp_below_low_mute = 1'b0;
    logic vp_above_restart = 1'b1;
    logic por_event = 1'b0;
    wire logic svr_at_half;
    wire logic svr_below_0v7;
    apms_pkg::apms_sense_s sense;
    apms_pkg::apms_ctrl_s ctrl;
    logic power_on_reset_flag;
    logic diagnostic_flag_pin_out;
    logic diagnostic_flag_pin_oe_n;
    logic speaker_check_done;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign sense = {vp_below_10v, vp_below_low_mute, vp_above_restart, svr_at_half,
        svr_below_0v7, por_event};
    apms_sequencer #(.FAST_MUTE_CYC(FM), .SOFT_MUTE_CYC(16), .FAULT_CHECK_CYC(4)) uut (
        .sys_clk, .rst_n, .address_select_grounded, .stb_above_2v5, .stb_above_5v9,
        .amplifier_on_bit, .mute_bits, .threshold_7v2_select, .best_eff_request, .sense,
        .ctrl, .power_on_reset_flag, .diagnostic_flag_pin_out, .diagnostic_flag_pin_oe_n,
        .speaker_check_done);
    apms_svr_model u_svr (.sys_clk, .rst_n, .ctrl, .svr_at_half, .svr_below_0v7);
    always #20 sys_clk = ~sys_clk;
    // ----
    // Helpers
    // ----
    task test_done;
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard: the whole run needs about 400 cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            err_count++;
            test_done();
        end
    end
    task check(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return ctrl.ramp_enable;
            1: return ctrl.mute;
            2: return ctrl.fast_mute;
            3: return ctrl.svr_discharge;
            4: return ctrl.ac_ground_cap_discharge;
            default: return ctrl.fault_check;
        endcase
    endfunction
    task wait_sig(input int k, input logic v);
        int i;
        for (i = 0; i < 300 && sig(k) !== v; i++)
            @(negedge sys_clk);
        check(sig(k) === v, "wait ran out");
    endtask
    task start_on(input logic mb);
        @(posedge sys_clk);
        mute_bits <= mb;
        amplifier_on_bit <= 1'b1;
        wait_sig(0, 1'b1);
        check(ctrl.mute === 1'b1, "ramp unmuted");
    endtask
    // ----
    // Scenarios
    // ----
    task t_reset;
        tick(1);
        check(power_on_reset_flag === 1'b1 && ctrl === '0, "reset state");
        tick(3);
        check(diagnostic_flag_pin_oe_n === 1'b0 && diagnostic_flag_pin_out === 1'b0, "diagnostic_flag_pin");
    endtask
    task t_bus_start;
        start_on(1'b1);
        tick(3);
        check(power_on_reset_flag === 1'b0 && diagnostic_flag_pin_oe_n === 1'b1, "flag");
        tick(30);
        check(ctrl.mute === 1'b1 && speaker_check_done === 1'b0, "left mute");
        @(posedge sys_clk);
        mute_bits <= 1'b0;
        wait_sig(5, 1'b1);
        wait_sig(1, 1'b0);
        check(speaker_check_done === 1'b1, "no fault check");
    endtask
    task t_effic;
        @(posedge sys_clk);
        best_eff_request <= 1'b1;
        tick(3);
        check(ctrl.best_eff_enable === 1'b1 && ctrl.dc_follow_half_supply === 1'b0, "hi");
        @(posedge sys_clk);
        vp_below_10v <= 1'b1;
        tick(3);
        check(ctrl.best_eff_enable === 1'b0 && ctrl.dc_follow_half_supply === 1'b1, "lo");
        @(posedge sys_clk);
        vp_below_10v <= 1'b0;
    endtask
    task t_soft_off;
        @(posedge sys_clk);
        amplifier_on_bit <= 1'b0;
        wait_sig(3, 1'b1);
        check(ctrl.fast_mute === 1'b0 && ctrl.mute === 1'b1, "soft off");
        wait_sig(3, 1'b0);
        check(ctrl.ramp_enable === 1'b0, "not off");
    endtask
    task t_low;
        int n;
        @(posedge sys_clk);
        threshold_7v2_select <= 1'b1;
        start_on(1'b0);
        wait_sig(1, 1'b0);
        check(ctrl.threshold_7v2 === 1'b1, "threshold");
        @(posedge sys_clk);
        vp_below_low_mute <= 1'b1;
        vp_above_restart <= 1'b0;
        wait_sig(2, 1'b1);
        for (n = 0; n < 300 && ctrl.ac_ground_cap_discharge !== 1'b1; n++)
            @(negedge sys_clk);
        check(n >= FM - 1 && n <= FM + 4 && ctrl.svr_discharge === 1'b1, "low mute");
        @(posedge sys_clk);
        vp_below_low_mute <= 1'b0;
        vp_above_restart <= 1'b1;
        threshold_7v2_select <= 1'b0;
        wait_sig(0, 1'b1);
        wait_sig(1, 1'b0);
    endtask
    task t_por;
        @(posedge sys_clk);
        por_event <= 1'b1;
        @(posedge sys_clk);
        por_event <= 1'b0;
        tick(1);
        check(power_on_reset_flag === 1'b1 && ctrl.ramp_enable === 1'b0, "por");
        @(posedge sys_clk);
        vp_below_low_mute <= 1'b1;
        tick(5);
        @(posedge sys_clk);
        vp_below_low_mute <= 1'b0;
        tick(60);
        check(ctrl.ramp_enable === 1'b0 && diagnostic_flag_pin_oe_n === 1'b0, "restart");
        @(posedge sys_clk);
        amplifier_on_bit <= 1'b0;
        start_on(1'b0);
        wait_sig(1, 1'b0);
    endtask
    task t_pin;
        @(posedge sys_clk);
        stb_above_2v5 <= 1'b0;
        wait_sig(2, 1'b1);
        wait_sig(3, 1'b1);
        @(posedge sys_clk);
        amplifier_on_bit <= 1'b0;
        wait_sig(3, 1'b0);
        @(posedge sys_clk);
        stb_above_2v5 <= 1'b1;
    endtask
    task t_legacy;
        @(posedge sys_clk);
        address_select_grounded <= 1'b1;
        threshold_7v2_select <= 1'b1;
        wait_sig(0, 1'b1);
        tick(30);
        check(ctrl.mute === 1'b1 && ctrl.threshold_7v2 === 1'b0, "legacy mute");
        @(posedge sys_clk);
        stb_above_5v9 <= 1'b1;
        wait_sig(1, 1'b0);
        @(posedge sys_clk);
        vp_below_low_mute <= 1'b1;
        vp_above_restart <= 1'b0;
        wait_sig(4, 1'b1);
        @(posedge sys_clk);
        vp_below_low_mute <= 1'b0;
        vp_above_restart <= 1'b1;
        wait_sig(0, 1'b1);
        wait_sig(1, 1'b0);
        @(posedge sys_clk);
        stb_above_5v9 <= 1'b0;
        tick(20);
        check(ctrl.mute === 1'b1, "mute level");
        @(posedge sys_clk);
        stb_above_2v5 <= 1'b0;
        wait_sig(3, 1'b1);
        wait_sig(3, 1'b0);
    endtask
    initial
    begin
        tick(2);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_bus_start();
        t_effic();
        t_soft_off();
        t_low();
        t_por();
        t_pin();
        t_legacy();
        test_done();
    end
endmodule
